// ==== dcs_pkg.sv ====
package dcs_pkg;

    // Control word bit positions.
    localparam int CW_REF_LSB = 0;
    localparam int CW_REF_MSB = 1;
    localparam int CW_DC_BRAKE_N = 2;
    localparam int CW_COAST_N = 3;
    localparam int CW_QSTOP_N = 4;
    localparam int CW_HOLD_N = 5;
    localparam int CW_START = 6;
    localparam int CW_RESET = 7;
    localparam int CW_JOG = 8;
    localparam int CW_RAMP2 = 9;
    localparam int CW_VALID = 10;
    localparam int CW_RELAY1 = 11;
    localparam int CW_RELAY2 = 12;
    localparam int CW_SETUP_LSB = 13;
    localparam int CW_SETUP_MSB = 14;
    localparam int CW_REVERSE = 15;

    // Status word bit positions.
    localparam int SW_CTRL_READY = 0;
    localparam int SW_DRIVE_READY = 1;
    localparam int SW_ENABLE = 2;
    localparam int SW_TRIP = 3;
    localparam int SW_ERROR = 4;
    localparam int SW_UNUSED = 5;
    localparam int SW_TRIPLOCK = 6;
    localparam int SW_WARNING = 7;
    localparam int SW_AT_REF = 8;
    localparam int SW_BUS_CTRL = 9;
    localparam int SW_FREQ_OK = 10;
    localparam int SW_IN_OP = 11;
    localparam int SW_AUTO_START = 12;
    localparam int SW_VOLT_EXC = 13;
    localparam int SW_TORQUE_EXC = 14;
    localparam int SW_TIMER_EXC = 15;

    // Reset values.
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] RPT_RESET = 16'h0000;

    // Reversing source settings.
    typedef enum logic [1:0] {
        DCS_REV_DIGITAL = 2'h0,
        DCS_REV_SERIAL = 2'h1,
        DCS_REV_OR = 2'h2,
        DCS_REV_AND = 2'h3
    } dcs_rev_src_t;

    // Stop mode chosen by the decoder, Gray coded along the usual path.
    typedef enum logic [2:0] {
        DCS_RUN = 3'h0,
        DCS_RAMP = 3'h1,
        DCS_QUICK = 3'h3,
        DCS_DCBRAKE = 3'h2,
        DCS_COAST = 3'h6
    } dcs_stop_t;

endpackage : dcs_pkg

// ==== dcs_report.sv ====
`timescale 1ns/1ns
`default_nettype none
// Assembles the status word from drive conditions, registered.
module dcs_report (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic ctrl_ready,
    input wire logic coast_active,
    input wire logic motor_released,
    input wire logic trip,
    input wire logic error_no_trip,
    input wire logic trip_locked,
    input wire logic warning,
    input wire logic at_reference,
    input wire logic local_stop,
    input wire logic local_ref,
    input wire logic freq_in_limits,
    input wire logic start_present,
    input wire logic freq_nonzero,
    input wire logic overtemp_stop,
    input wire logic dc_volt_bad,
    input wire logic current_exceeded,
    input wire logic thermal_timer_exc,
    input wire logic link_lost,
    input wire logic comm_fault,
    output logic [15:0] drive_report_word
);
    import dcs_pkg::*;

    // Combined next value of the status word.
    logic [15:0] rpt_d;

    // Each bit follows its cause; a lost link blanks everything.
    always_comb begin
        rpt_d = RPT_RESET;
        // R15: ready, drive ready, enable
        rpt_d[SW_CTRL_READY] = ctrl_ready & ~trip;
        rpt_d[SW_DRIVE_READY] = ctrl_ready & ~trip & coast_active;
        rpt_d[SW_ENABLE] = ~motor_released;
        // R16: fault state bits
        rpt_d[SW_TRIP] = trip;
        rpt_d[SW_ERROR] = error_no_trip;
        rpt_d[SW_TRIPLOCK] = trip_locked;
        // R23: unused bit zero
        rpt_d[SW_UNUSED] = 1'b0;
        // R17: any warning
        rpt_d[SW_WARNING] = warning;
        // R18: speed matches reference
        rpt_d[SW_AT_REF] = at_reference;
        // R19: bus control possible
        rpt_d[SW_BUS_CTRL] = ~local_stop & ~local_ref;
        // R20: limits and operation
        rpt_d[SW_FREQ_OK] = freq_in_limits;
        rpt_d[SW_IN_OP] = start_present | freq_nonzero;
        // R21: thermal, voltage, current
        rpt_d[SW_AUTO_START] = overtemp_stop;
        rpt_d[SW_VOLT_EXC] = dc_volt_bad;
        rpt_d[SW_TORQUE_EXC] = current_exceeded;
        rpt_d[SW_TIMER_EXC] = thermal_timer_exc;
        // R22: blank on link loss
        if (link_lost || comm_fault) begin
            rpt_d = 16'h0000;
        end
    end

    // The word is registered so the master sees a clean value.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_report_word <= RPT_RESET;
        end else if (clk_en) begin
            drive_report_word <= rpt_d;
        end
    end

endmodule : dcs_report
`default_nettype wire

// ==== dcs_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R01: Bits 1:0 pick preset reference.
// R02: Bit 2 low applies DC brake.
// R03: Bit 3 low coasts immediately.
// R04: Bit 4 low quick-stops on ramp.
// R05: Bit 5 low freezes output frequency.
// R06: Frozen: only coast or brake stops.
// R07: Bit 6 low ramps to stop.
// R08: Bit 7 rising edge clears trip.
// R09: Bit 8 high selects jog speed.
// R10: Bit 9 selects ramp set two.
// R11: Bit 10 low ignores whole word.
// R12: Bits 11, 12 drive enabled relays.
// R13: Bits 14:13 pick set-up if multi.
// R14: Bit 15 reverses if source allows.
// R15: Status ready, drive ready, enable bits.
// R16: Status trip, error, triplock bits.
// R17: Status bit 7 shows warnings.
// R18: Status bit 8 speed equals reference.
// R19: Status bit 9 bus control possible.
// R20: Status limits and in-operation bits.
// R21: Status thermal, voltage, current, timer.
// R22: Link loss zeroes status word.
// R23: Status bit 5 always zero.
// R24: Word latched whole before decoding.
module dcs_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Control word from the master, taken when cmd_write is high and its valid bit is set.
    input wire logic [15:0] cmd_word_in,
    input wire logic cmd_write,
    // Configuration of the drive.
    input wire logic relay1_sel_cw,
    input wire logic relay2_sel_cw,
    input wire logic multi_setup_en,
    input wire dcs_pkg::dcs_rev_src_t rev_src,
    input wire logic din_reverse,
    // Digital inputs able to stop while frozen, and speed up/down.
    input wire logic din_dc_brake,
    input wire logic din_coast,
    input wire logic din_reset_coast,
    input wire logic din_speed_up,
    input wire logic din_slow_down,
    // Drive condition inputs for the status word.
    input wire logic ctrl_ready,
    input wire logic motor_released,
    input wire logic trip,
    input wire logic error_no_trip,
    input wire logic trip_locked,
    input wire logic warning,
    input wire logic at_reference,
    input wire logic local_stop,
    input wire logic local_ref,
    input wire logic freq_in_limits,
    input wire logic start_present,
    input wire logic freq_nonzero,
    input wire logic overtemp_stop,
    input wire logic dc_volt_bad,
    input wire logic current_exceeded,
    input wire logic thermal_timer_exc,
    input wire logic link_lost,
    input wire logic comm_fault,
    // Decoded commands to the motor control.
    output logic [15:0] drive_command_word,
    output logic [1:0] preset_sel,
    output dcs_pkg::dcs_stop_t stop_mode,
    output logic output_off,
    output logic start_enable,
    output logic freeze,
    output logic freq_up,
    output logic freq_down,
    output logic trip_clear,
    output logic jog_sel,
    output logic ramp2_sel,
    output logic relay1_on,
    output logic relay2_on,
    output logic [1:0] setup_sel,
    output logic reverse,
    output logic [15:0] drive_report_word
);
    import dcs_pkg::*;

    // Previous accepted reset bit, for edge detection.
    logic reset_bit_q;
    // Stop mode next value.
    dcs_stop_t stop_d;
    // Active command word view, zero when nothing accepted yet.
    logic [15:0] cw;

    assign cw = drive_command_word;

    // R24: latch word whole
    // R11: ignore invalid words
    // The word is stored only when its valid bit is set, so a telegram
    // carrying a parameter access never disturbs the running command.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_command_word <= CMD_RESET;
        end else if (clk_en && cmd_write && cmd_word_in[CW_VALID]) begin
            drive_command_word <= cmd_word_in;
        end
    end

    // Stop priority: coast over DC brake over quick stop over ramp.
    // While frozen, only coast and brake (bus or digital) may stop.
    always_comb begin
        stop_d = DCS_RUN;
        if (!cw[CW_VALID]) begin
            // Nothing accepted yet; hold the motor off by coasting.
            stop_d = DCS_COAST;
        // R03: coast stop
        end else if (!cw[CW_COAST_N] || din_coast || din_reset_coast) begin
            stop_d = DCS_COAST;
        // R02: DC brake stop
        end else if (!cw[CW_DC_BRAKE_N] || din_dc_brake) begin
            stop_d = DCS_DCBRAKE;
        // R06: frozen blocks ramps
        end else if (!cw[CW_HOLD_N]) begin
            stop_d = DCS_RUN;
        // R04: quick stop ramp
        end else if (!cw[CW_QSTOP_N]) begin
            stop_d = DCS_QUICK;
        // R07: ramp stop
        end else if (!cw[CW_START]) begin
            stop_d = DCS_RAMP;
        end else begin
            stop_d = DCS_RUN;
        end
    end

    // Stop mode and derived enables.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_mode <= DCS_COAST;
            output_off <= 1'b1;
            start_enable <= 1'b0;
        end else if (clk_en) begin
            stop_mode <= stop_d;
            output_off <= (stop_d == DCS_COAST);
            start_enable <= (stop_d == DCS_RUN);
        end
    end

    // Freeze and the digital speed up/down that alone may move it.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            freeze <= 1'b0;
            freq_up <= 1'b0;
            freq_down <= 1'b0;
        end else if (clk_en) begin
            // R05: hold output frequency
            freeze <= cw[CW_VALID] & ~cw[CW_HOLD_N];
            freq_up <= cw[CW_VALID] & ~cw[CW_HOLD_N] & din_speed_up;
            freq_down <= cw[CW_VALID] & ~cw[CW_HOLD_N] & din_slow_down;
        end
    end

    // Trip clear pulses one cycle on a rising reset bit only.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_bit_q <= 1'b0;
            trip_clear <= 1'b0;
        end else if (clk_en) begin
            reset_bit_q <= cw[CW_RESET];
            // R08: rising edge reset
            trip_clear <= cw[CW_RESET] & ~reset_bit_q;
        end
    end

    // Reference, ramp, jog and set-up selections.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            preset_sel <= 2'h0;
            jog_sel <= 1'b0;
            ramp2_sel <= 1'b0;
            setup_sel <= 2'h0;
        end else if (clk_en) begin
            // R01: preset reference index
            preset_sel <= cw[CW_REF_MSB:CW_REF_LSB];
            // R09: jog speed
            jog_sel <= cw[CW_JOG];
            // R10: ramp set select
            ramp2_sel <= cw[CW_RAMP2];
            // R13: set-up select
            if (multi_setup_en) begin
                setup_sel <= cw[CW_SETUP_MSB:CW_SETUP_LSB];
            end
        end
    end

    // Relays and direction, gated by their function settings.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            relay1_on <= 1'b0;
            relay2_on <= 1'b0;
            reverse <= 1'b0;
        end else if (clk_en) begin
            // R12: relay outputs
            relay1_on <= relay1_sel_cw & cw[CW_RELAY1];
            relay2_on <= relay2_sel_cw & cw[CW_RELAY2];
            // R14: reverse by source
            unique case (rev_src)
                DCS_REV_DIGITAL: reverse <= din_reverse;
                DCS_REV_SERIAL: reverse <= cw[CW_REVERSE];
                DCS_REV_OR: reverse <= cw[CW_REVERSE] | din_reverse;
                DCS_REV_AND: reverse <= cw[CW_REVERSE] & din_reverse;
            endcase
        end
    end

    // Status word assembly; coast_active is high while stop_mode is DCS_COAST.
    dcs_report u_report (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .ctrl_ready(ctrl_ready),
        .coast_active(stop_mode == DCS_COAST),
        .motor_released(motor_released),
        .trip(trip),
        .error_no_trip(error_no_trip),
        .trip_locked(trip_locked),
        .warning(warning),
        .at_reference(at_reference),
        .local_stop(local_stop),
        .local_ref(local_ref),
        .freq_in_limits(freq_in_limits),
        .start_present(start_present),
        .freq_nonzero(freq_nonzero),
        .overtemp_stop(overtemp_stop),
        .dc_volt_bad(dc_volt_bad),
        .current_exceeded(current_exceeded),
        .thermal_timer_exc(thermal_timer_exc),
        .link_lost(link_lost),
        .comm_fault(comm_fault),
        .drive_report_word(drive_report_word)
    );

endmodule : dcs_top
`default_nettype wire

// ==== dcs_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// Watches the decoder and the status word at the top ports.
module dcs_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [15:0] cmd_word_in,
    input wire logic cmd_write,
    input wire logic relay1_sel_cw,
    input wire logic trip,
    input wire logic warning,
    input wire logic link_lost,
    input wire logic comm_fault,
    input wire logic [15:0] drive_command_word,
    input wire logic [1:0] preset_sel,
    input wire logic trip_clear,
    input wire logic jog_sel,
    input wire logic relay1_on,
    input wire logic [15:0] drive_report_word
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // A status cause only shows while the link is healthy.
    wire st_ok = clk_en && !link_lost && !comm_fault;
    property p_latch;
        clk_en && cmd_write && cmd_word_in[10]
            |=> drive_command_word == $past(cmd_word_in);
    endproperty
    a_latch: assert property (p_latch)
        else $error("Command word not latched whole.");
    property p_refuse;
        clk_en && cmd_write && !cmd_word_in[10] |=> $stable(drive_command_word);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("Invalid word was taken.");
    property p_preset;
        clk_en |=> preset_sel == $past(drive_command_word[1:0]);
    endproperty
    a_preset: assert property (p_preset)
        else $error("Preset index wrong.");
    property p_jog;
        clk_en |=> jog_sel == $past(drive_command_word[8]);
    endproperty
    a_jog: assert property (p_jog)
        else $error("Jog select wrong.");
    property p_relay;
        clk_en |=> relay1_on ==
            ($past(drive_command_word[11]) && $past(relay1_sel_cw));
    endproperty
    a_relay: assert property (p_relay)
        else $error("Relay one wrong.");
    property p_clear_only;
        trip_clear |-> $past(drive_command_word[7])
            && !$past(drive_command_word[7], 2);
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("Trip clear without a rising reset bit.");
    property p_clear_fire;
        clk_en && drive_command_word[7] && !$past(drive_command_word[7])
            |=> trip_clear;
    endproperty
    a_clear_fire: assert property (p_clear_fire)
        else $error("Rising reset bit gave no trip clear.");
    property p_link;
        clk_en && (link_lost || comm_fault) |=> drive_report_word == 16'h0000;
    endproperty
    a_link: assert property (p_link)
        else $error("Status word not cleared on link loss.");
    property p_fault;
        st_ok |=> drive_report_word[3] == $past(trip)
            && drive_report_word[7] == $past(warning);
    endproperty
    a_fault: assert property (p_fault)
        else $error("Trip or warning bit wrong.");
    property p_unused;
        drive_report_word[5] == 1'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("Spare status bit set.");
endmodule : dcs_checker
bind dcs_top dcs_checker u_chk (.*);
`default_nettype wire

// ==== dcs_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Bus master: hands whole words over, one per clock, then lets go.
module dcs_master_model (
    input wire logic mclk,
    output logic [15:0] cmd_word_in,
    output logic cmd_write
);
    initial begin
        cmd_word_in = 16'h0000;
        cmd_write = 1'h0;
    end
    // whole words, valid flag set by caller
    // Released data flips so a stale word cannot pass for a fresh one.
    task automatic send(input logic [15:0] w [$]);
        foreach (w[i]) begin
            @(posedge mclk);
            #1;
            cmd_word_in = w[i];
            cmd_write = 1'h1;
        end
        @(posedge mclk);
        #1;
        cmd_write = 1'h0;
        cmd_word_in = ~cmd_word_in;
    endtask : send
endmodule : dcs_master_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Runs a table of command words, then edge, refusal and status cases.
module tb_top;
    import dcs_pkg::*;
    logic mclk = '0, sys_rst = '1, clk_en = '1;
    logic relay1_sel_cw = '1, relay2_sel_cw = '0, multi_setup_en = '1;
    dcs_rev_src_t rev_src = DCS_REV_SERIAL;
    logic din_reverse = '0, din_dc_brake = '0, din_coast = '0;
    logic din_reset_coast = '0, din_speed_up = '0, din_slow_down = '0;
    logic ctrl_ready = '1, motor_released = '0, trip = '0, warning = '0;
    logic error_no_trip = '0, trip_locked = '0, at_reference = '0;
    logic local_stop = '0, local_ref = '0, freq_in_limits = '0;
    logic start_present = '0, freq_nonzero = '0, overtemp_stop = '0;
    logic dc_volt_bad = '0, current_exceeded = '0, thermal_timer_exc = '0;
    logic link_lost = '0, comm_fault = '0, cmd_write, output_off;
    logic start_enable, freeze, freq_up, freq_down, trip_clear, jog_sel;
    logic ramp2_sel, relay1_on, relay2_on, reverse;
    logic [15:0] cmd_word_in, drive_command_word, drive_report_word;
    logic [1:0] preset_sel, setup_sel;
    dcs_stop_t stop_mode;
    int bad_count = 0, checks = 0;
    typedef struct {logic [15:0] w; logic [1:0] ps; dcs_stop_t sm; logic fz;}
        dcs_row_t;
    // Each row: word sent, then preset, stop mode and freeze expected.
    dcs_row_t rows [10] = '{
        '{16'h047f, 2'h3, DCS_RUN, 1'h0}, '{16'h047c, 2'h0, DCS_RUN, 1'h0},
        '{16'h047d, 2'h1, DCS_RUN, 1'h0}, '{16'h047e, 2'h2, DCS_RUN, 1'h0},
        '{16'h047b, 2'h3, DCS_DCBRAKE, 1'h0}, '{16'h0477, 2'h3, DCS_COAST, 1'h0},
        '{16'h046f, 2'h3, DCS_QUICK, 1'h0}, '{16'h043f, 2'h3, DCS_RAMP, 1'h0},
        '{16'h040f, 2'h3, DCS_RUN, 1'h1}, '{16'h041b, 2'h3, DCS_DCBRAKE, 1'h1}};
    always #50 mclk = ~mclk;
    dcs_master_model u_master (.mclk(mclk), .cmd_word_in(cmd_word_in),
        .cmd_write(cmd_write));
    dcs_top u_dut (.*);
    // Compares with case equality, so an unknown never matches.
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Lets the decode stage land after the word is latched.
    task automatic settle;
        @(posedge mclk);
        #1;
    endtask : settle
    task automatic results;
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    // Cuts a hang short; the whole run needs well under this span.
    initial begin
        #100000;
        bad_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge mclk);
        chk("rst_stop", DCS_COAST, stop_mode);
        chk("rst_off", 1'h1, output_off);
        chk("rst_word", 16'h0000, drive_report_word);
        #1 sys_rst = '0;
        foreach (rows[i]) begin
            u_master.send('{rows[i].w});
            settle();
            chk("preset", rows[i].ps, preset_sel);
            chk("stop", rows[i].sm, stop_mode);
            chk("freeze", rows[i].fz, freeze);
        end
        // A coasting input still stops a frozen drive.
        din_coast = '1;
        u_master.send('{16'h041f});
        settle();
        chk("frz_coast", DCS_COAST, stop_mode);
        din_coast = '0;
        // A frozen but running drive still follows the speed-up input.
        din_speed_up = '1;
        u_master.send('{16'h040f});
        settle();
        chk("frz_up", 2'h2, {freq_up, freq_down});
        chk("start_en", 1'h1, start_enable);
        din_speed_up = '0;
        // The invalid second word must leave the first in place.
        u_master.send('{16'h047f, 16'h0000});
        chk("refused", 16'h047f, drive_command_word);
        u_master.send('{16'h04ff, 16'hff7f});
        chk("clr_pulse", 1'h1, trip_clear);
        chk("b2b_word", 16'hff7f, drive_command_word);
        settle();
        chk("clr_end", 1'h0, trip_clear);
        chk("relays", 2'h1, {relay2_on, relay1_on});
        chk("setup", 2'h3, setup_sel);
        chk("reverse", 1'h1, reverse);
        chk("jog_ramp2", 2'h3, {jog_sel, ramp2_sel});
        rev_src = DCS_REV_DIGITAL;
        multi_setup_en = '0;
        u_master.send('{16'h04ff, 16'h04ff});
        chk("clr_again", 1'h1, trip_clear);
        settle();
        chk("clr_steady", 1'h0, trip_clear);
        chk("rev_dig", 1'h0, reverse);
        chk("setup_hold", 2'h3, setup_sel);
        chk("relay_off", 1'h0, relay1_on);
        // With the clock enable low a valid word must not be taken.
        clk_en = '0;
        u_master.send('{16'h047c});
        settle();
        chk("en_hold", 16'h04ff, drive_command_word);
        chk("en_preset", 2'h3, preset_sel);
        clk_en = '1;
        // Every status cause raised at once except motor_released, local_stop, local_ref and freq_nonzero.
        {trip, warning, error_no_trip, trip_locked, at_reference} = '1;
        {freq_in_limits, start_present, overtemp_stop, dc_volt_bad} = '1;
        {current_exceeded, thermal_timer_exc} = '1;
        settle();
        chk("status", 16'hffdc, drive_report_word);
        link_lost = '1;
        settle();
        chk("link_lost", 16'h0000, drive_report_word);
        {link_lost, comm_fault, trip} = 3'h2;
        settle();
        chk("comm_fault", 16'h0000, drive_report_word);
        comm_fault = '0;
        settle();
        chk("ready", 2'h1, drive_report_word[1:0]);
        results();
    end
endmodule : tb_top
`default_nettype wire
